// ---- verilog/usbd_pkg.sv ----
// Constants, field layout and types for the USB event and isochronous block
package usbd_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] MISS_LIMIT = 2'h3;
  localparam int NUM_EP = 8;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_EP0 = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h40;
  localparam logic [7:0] OFS_STS = 8'h44;
  localparam logic [7:0] OFS_FN = 8'h48;
  localparam logic [7:0] OFS_ADDR = 8'h4c;
  localparam logic [7:0] OFS_PULL = 8'h50;

  // ------------------------------------------------------------------
  // Endpoint register fields
  // ------------------------------------------------------------------
  localparam int TX_ST_LSB = 4;
  localparam int TX_TOG = 6;
  localparam int TX_DONE = 7;
  localparam int KIND_BIT = 8;
  localparam int TYPE_LSB = 9;
  localparam int RX_ST_LSB = 12;
  localparam int RX_TOG = 14;
  localparam int RX_DONE = 15;
  localparam logic [15:0] EP_RW_MASK = 16'h777f;
  localparam logic [15:0] EP_W0C_MASK = 16'h8080;
  localparam logic [15:0] EP_RESET = 16'h0000;
  localparam logic [1:0] CLASS_BULK = 2'h0;
  localparam logic [1:0] CLASS_ISO = 2'h2;
  localparam logic [1:0] ST_DIS = 2'h0;
  localparam logic [1:0] ST_STALL = 2'h1;
  localparam logic [1:0] ST_NAK = 2'h2;
  localparam logic [1:0] ST_VALID = 2'h3;

  // ------------------------------------------------------------------
  // Control, status, frame and address register fields
  // ------------------------------------------------------------------
  localparam int CTRL_CORE_RST = 0;
  localparam int CTRL_PWR_DN = 1;
  localparam int CTRL_LP = 2;
  localparam int CTRL_FSUSP = 3;
  localparam int CTRL_RESUME = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0003;
  localparam int FLG_ESOF = 8;
  localparam int FLG_SOF = 9;
  localparam int FLG_RST = 10;
  localparam int FLG_SUSP = 11;
  localparam int FLG_WKUP = 12;
  localparam int FLG_ERR = 13;
  localparam int FLG_CTRS = 15;
  localparam logic [15:0] FLG_MASK = 16'h3f00;
  localparam int STS_DIR = 4;
  localparam int FN_DM = 14;
  localparam int FN_DP = 15;
  localparam int ADDR_FEN = 7;
  localparam int PULL_BIT = 25;

  // ------------------------------------------------------------------
  // Link state
  // ------------------------------------------------------------------
  typedef enum logic [0:0] {LINK_ACTIVE, LINK_SUSP} usbd_link_type;
endpackage

// ---- verilog/usbd_tick_if.sv ----
// Millisecond tick carrier between the core and its timer
`timescale 1ns/100ps
interface usbd_tick_if;
  logic tick;
  logic restart;
  modport owner (input restart, output tick);
  modport user (output restart, input tick);
endinterface

// ---- verilog/usbd_ms_timer.sv ----
// Millisecond tick divider
`timescale 1ns/100ps
module usbd_ms_timer #(
  parameter int CYCLES = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  usbd_tick_if.owner tk
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] cnt;

  // Free count, one-cycle tick at the end of each period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tk.tick <= 1'b0;
    end else if (tk.restart) begin
      cnt <= '0;
      tk.tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= '0;
      tk.tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tk.tick <= 1'b0;
    end
  end
endmodule

// ---- verilog/usbd_iso_events.sv ----
// USB device isochronous buffering, bus events and interrupt lines
//
// Contract
// RULE1: Isochronous endpoints: no handshake, always DATA0.
// RULE2: Buffer toggle selects device buffer per direction.
// RULE3: Two-way isochronous needs two endpoint registers.
// RULE4: Software presets toggle before first transfer.
// RULE5: Completion sets transfer flag, even on errors.
// RULE6: Isochronous CRC error also sets error flag.
// RULE7: Completion flips toggle, keeps endpoint states.
// RULE8: Transfer class 10 means isochronous.
// RULE9: Software sets isochronous state valid or disabled.
// RULE10: Software power-up sequence before use.
// RULE11: Pull-up enable bit 25, written by software.
// RULE12: Bus reset returns device to reset state.
// RULE13: Software enables endpoint 0 within 10 ms.
// RULE14: Three missed frames cause suspend and flag.
// RULE15: Bus reset still detected while suspended.
// RULE16: Resume starts either side, host ends it.
// RULE17: Line levels at wakeup identify wake cause.
// RULE18: Resume request only while force suspend set.
// RULE19: Low, high and wakeup interrupt lines.
// RULE20: Software endpoint initialization order.
// RULE21: Registers accept 16-bit and 32-bit accesses.
// RULE22: State 10 is NAK, 11 valid; NAK after receive.
// RULE23: State 00 disables, tokens get no response.
`timescale 1ns/100ps
module usbd_iso_events #(
  parameter int MS_CYCLES_P = usbd_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [1:0] reg_lane,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic tok_valid,
  input wire logic [2:0] tok_ep,
  input wire logic tok_in,
  output logic ans_valid,
  output logic ans_respond,
  output logic ans_handshake,
  output logic ans_stall,
  output logic ans_nak,
  output logic ans_data1,
  output logic ans_buf_sel,
  input wire logic done_valid,
  input wire logic [2:0] done_ep,
  input wire logic done_in,
  input wire logic done_crc_err,
  input wire logic done_overflow,
  input wire logic sof_seen,
  input wire logic [10:0] sof_frame,
  input wire logic bus_reset,
  input wire logic bus_activity,
  input wire logic dplus_level,
  input wire logic dminus_level,
  output logic irq_low,
  output logic irq_high,
  output logic irq_wakeup,
  output logic dp_pullup_en,
  output logic resume_drive,
  output logic suspended
);
  import usbd_pkg::*;

  // ------------------------------------------------------------------
  // Storage and decode
  // ------------------------------------------------------------------
  logic [15:0] ep [NUM_EP];
  logic [15:0] next_ep [NUM_EP];
  logic [15:0] ctrl;
  logic [15:0] flags;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [3:0] last_id;
  logic [10:0] frame;
  logic [1:0] wake_lines;
  logic [7:0] addr_reg;
  logic [1:0] missed;
  logic [2:0] dep_q;
  usbd_link_type link;
  usbd_link_type next_link;
  logic wlo;
  logic whi;
  logic ep_wr;
  logic ctrl_wr;
  logic core_clr;
  logic ep_clr;
  logic miss_hit;
  logic fsusp_wr;
  logic wake_ev;
  logic ctrs_any;
  logic hp_any;
  logic d_iso;
  logic d_tog;
  logic [1:0] d_st;
  logic tok_iso;
  logic tok_tog;
  logic [1:0] tok_st;
  logic [31:0] rd_mux;
  usbd_tick_if tk ();

  function automatic logic is_iso(input logic [15:0] e);
    return e[TYPE_LSB+1:TYPE_LSB] == CLASS_ISO; // RULE8
  endfunction

  // Lane strobes: low half-word or high half-word of a word
  assign wlo = reg_wr & reg_lane[0]; // RULE21
  assign whi = reg_wr & reg_lane[1]; // RULE21
  assign ep_wr = wlo && reg_addr[7:5] == 3'h0 && reg_addr[1:0] == 2'h0;
  assign ctrl_wr = wlo && reg_addr == OFS_CTRL;
  assign core_clr = ctrl[CTRL_CORE_RST] | ctrl[CTRL_PWR_DN];
  assign ep_clr = core_clr | bus_reset; // RULE12

  // ------------------------------------------------------------------
  // Millisecond timer
  // ------------------------------------------------------------------
  assign tk.restart = core_clr;

  usbd_ms_timer #(.CYCLES(MS_CYCLES_P)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .tk(tk)
  );

  // ------------------------------------------------------------------
  // Endpoint registers
  // ------------------------------------------------------------------
  // Software writes, then hardware completion, then reset clear
  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      next_ep[i] = ep[i];
      if (ep_wr && reg_addr[4:2] == 3'(i)) begin
        next_ep[i] = (reg_wdata[15:0] & EP_RW_MASK) |
                     (ep[i] & reg_wdata[15:0] & EP_W0C_MASK);
      end
      if (done_valid && done_ep == 3'(i)) begin
        if (is_iso(ep[i])) begin
          // Flag set and toggle flip, states kept even on errors
          if (done_in) begin
            next_ep[i][TX_DONE] = 1'b1; // RULE5
            next_ep[i][TX_TOG] = ~ep[i][TX_TOG]; // RULE7
          end else begin
            next_ep[i][RX_DONE] = 1'b1; // RULE5
            next_ep[i][RX_TOG] = ~ep[i][RX_TOG]; // RULE7
          end
        end else if (!done_crc_err && !done_overflow) begin
          if (done_in) begin
            next_ep[i][TX_DONE] = 1'b1;
            next_ep[i][TX_TOG] = ~ep[i][TX_TOG];
            next_ep[i][TX_ST_LSB+1:TX_ST_LSB] = ST_NAK;
          end else begin
            next_ep[i][RX_DONE] = 1'b1;
            next_ep[i][RX_TOG] = ~ep[i][RX_TOG];
            next_ep[i][RX_ST_LSB+1:RX_ST_LSB] = ST_NAK; // RULE22
          end
        end
      end
      if (ep_clr) begin
        next_ep[i] = EP_RESET; // RULE12
      end
    end
  end

  // Endpoint register bank
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EP; i++) begin
        ep[i] <= EP_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        ep[i] <= next_ep[i];
      end
    end
  end

  // Interrupt sources over all endpoints
  always_comb begin
    ctrs_any = 1'b0;
    hp_any = 1'b0;
    for (int i = 0; i < NUM_EP; i++) begin
      ctrs_any = ctrs_any | ep[i][RX_DONE] | ep[i][TX_DONE];
      if (is_iso(ep[i]) || (ep[i][TYPE_LSB+1:TYPE_LSB] == CLASS_BULK &&
          ep[i][KIND_BIT])) begin
        hp_any = hp_any | ep[i][RX_DONE] | ep[i][TX_DONE]; // RULE19
      end
    end
  end

  // ------------------------------------------------------------------
  // Token answers
  // ------------------------------------------------------------------
  assign tok_iso = is_iso(ep[tok_ep]);
  assign tok_tog = tok_in ? ep[tok_ep][TX_TOG] : ep[tok_ep][RX_TOG];
  assign tok_st = tok_in ? ep[tok_ep][TX_ST_LSB+1:TX_ST_LSB] :
                  ep[tok_ep][RX_ST_LSB+1:RX_ST_LSB];

  // Answer one cycle after each token, none while the core is held in reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ans_valid <= 1'b0;
      ans_respond <= 1'b0;
      ans_handshake <= 1'b0;
      ans_stall <= 1'b0;
      ans_nak <= 1'b0;
      ans_data1 <= 1'b0;
      ans_buf_sel <= 1'b0;
    end else begin
      ans_valid <= tok_valid & ~core_clr;
      if (tok_valid) begin
        ans_respond <= addr_reg[ADDR_FEN] && tok_st != ST_DIS; // RULE23
        ans_handshake <= ~tok_iso; // RULE1
        ans_stall <= ~tok_iso && tok_st == ST_STALL;
        ans_nak <= ~tok_iso && tok_st == ST_NAK;
        ans_data1 <= tok_iso ? 1'b0 : tok_tog; // RULE1
        ans_buf_sel <= tok_iso ? tok_tog : 1'b0; // RULE2
      end
    end
  end

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  // Resume request accepted only while force suspend already holds
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= {reg_wdata[15:8], 3'h0,
               reg_wdata[CTRL_RESUME] & ctrl[CTRL_FSUSP], // RULE18
               reg_wdata[3:0]};
    end
  end
  assign resume_drive = ctrl[CTRL_RESUME]; // RULE16

  // ------------------------------------------------------------------
  // Link state: suspend on missed frames, wake on bus signalling
  // ------------------------------------------------------------------
  assign miss_hit = tk.tick && !sof_seen && missed == MISS_LIMIT - 2'h1;
  assign fsusp_wr = ctrl_wr && reg_wdata[CTRL_FSUSP] && !ctrl[CTRL_FSUSP];
  assign wake_ev = link == LINK_SUSP && (bus_activity || bus_reset);

  // Next link state
  always_comb begin
    next_link = link;
    case (link)
      LINK_ACTIVE: begin
        if (miss_hit || fsusp_wr) begin
          next_link = LINK_SUSP; // RULE14
        end
      end
      LINK_SUSP: begin
        if (bus_reset || bus_activity) begin
          next_link = LINK_ACTIVE; // RULE15
        end
      end
      default: next_link = LINK_ACTIVE;
    endcase
    if (core_clr) begin
      next_link = LINK_ACTIVE;
    end
  end

  // Link state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link <= LINK_ACTIVE;
      suspended <= 1'b0;
    end else begin
      link <= next_link;
      suspended <= next_link == LINK_SUSP;
    end
  end

  // Missed frame counter, cleared by each frame start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      missed <= 2'h0;
    end else if (core_clr || sof_seen || link == LINK_SUSP) begin
      missed <= 2'h0;
    end else if (tk.tick && missed != MISS_LIMIT) begin
      missed <= missed + 2'h1; // RULE14
    end
  end

  // Frame number caught at each frame start, line levels caught at wakeup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame <= 11'h000;
      wake_lines <= 2'h0;
    end else begin
      if (sof_seen) begin
        frame <= sof_frame;
      end
      if (wake_ev) begin
        wake_lines <= {dplus_level, dminus_level}; // RULE17
      end
    end
  end

  // ------------------------------------------------------------------
  // Status flags: hardware set wins over software clear
  // ------------------------------------------------------------------
  always_comb begin
    set_vec = 16'h0000;
    if (!core_clr) begin
      set_vec[FLG_ESOF] = tk.tick && !sof_seen && link == LINK_ACTIVE;
      set_vec[FLG_SOF] = sof_seen;
      set_vec[FLG_RST] = bus_reset; // RULE15
      set_vec[FLG_SUSP] = miss_hit && link == LINK_ACTIVE; // RULE14
      set_vec[FLG_WKUP] = wake_ev;
      set_vec[FLG_ERR] = done_valid && !done_in && done_crc_err; // RULE6
    end
  end
  assign clr_vec = (wlo && reg_addr == OFS_STS) ?
                   (~reg_wdata[15:0] & FLG_MASK) : 16'h0000;

  // Sticky flags and last completed endpoint
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 16'h0000;
      last_id <= 4'h0;
    end else begin
      flags <= ((flags & ~clr_vec) | set_vec) & FLG_MASK;
      if (done_valid && !ep_clr) begin
        last_id <= {done_in, done_ep};
      end
    end
  end

  // ------------------------------------------------------------------
  // Address and pull-up registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 8'h00;
    end else if (ep_clr) begin
      addr_reg <= 8'h00; // RULE12
    end else if (wlo && reg_addr == OFS_ADDR) begin
      addr_reg <= reg_wdata[7:0];
    end
  end

  // Pull-up survives core resets, only software moves it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dp_pullup_en <= 1'b0;
    end else if (whi && reg_addr == OFS_PULL) begin
      dp_pullup_en <= reg_wdata[PULL_BIT]; // RULE11
    end
  end

  // ------------------------------------------------------------------
  // Interrupt lines
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_low <= 1'b0;
      irq_high <= 1'b0;
      irq_wakeup <= 1'b0;
    end else begin
      irq_low <= |({ctrs_any, flags[14:8]} & ctrl[15:8]); // RULE19
      irq_high <= hp_any & ctrl[FLG_CTRS]; // RULE19
      irq_wakeup <= flags[FLG_WKUP] & ctrl[FLG_WKUP]; // RULE19
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr[7:5] == 3'h0 && reg_addr[1:0] == 2'h0) begin
      rd_mux = {16'h0000, ep[reg_addr[4:2]]};
    end else begin
      case (reg_addr)
        OFS_CTRL: rd_mux = {16'h0000, ctrl};
        OFS_STS: rd_mux = {16'h0000, ctrs_any, flags[14:8], 3'h0,
                           last_id[3], 1'b0, last_id[2:0]};
        OFS_FN: rd_mux = {16'h0000, wake_lines, missed, 1'b0, frame};
        OFS_ADDR: rd_mux = {24'h000000, addr_reg};
        OFS_PULL: rd_mux = {6'h00, dp_pullup_en, 25'h0000000};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands for one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  assign d_iso = is_iso(ep[done_ep]);
  assign d_tog = done_in ? ep[done_ep][TX_TOG] : ep[done_ep][RX_TOG];
  assign d_st = done_in ? ep[done_ep][TX_ST_LSB+1:TX_ST_LSB] :
                ep[done_ep][RX_ST_LSB+1:RX_ST_LSB];

  // Endpoint index of the previous cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dep_q <= 3'h0;
    end else begin
      dep_q <= done_ep;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_iso_data0;
    ans_valid && !ans_handshake |-> !ans_data1 && !ans_stall && !ans_nak;
  endproperty
  a_iso_data0: assert property (p_iso_data0) // RULE1
    else $error("isochronous answer not plain DATA0");

  property p_buf_sel;
    tok_valid && tok_iso && !core_clr |=> ans_buf_sel == $past(tok_tog);
  endproperty
  a_buf_sel: assert property (p_buf_sel) // RULE2
    else $error("buffer select differs from toggle");

  property p_iso_flag;
    done_valid && d_iso && done_in && !ep_clr |=> ep[dep_q][TX_DONE];
  endproperty
  a_iso_flag: assert property (p_iso_flag) // RULE5
    else $error("isochronous completion left flag clear");

  property p_iso_err;
    done_valid && d_iso && !done_in && done_crc_err && !ep_clr
      |=> flags[FLG_ERR] && ep[dep_q][RX_DONE];
  endproperty
  a_iso_err: assert property (p_iso_err) // RULE6
    else $error("CRC error not reported on isochronous receive");

  property p_iso_tog;
    done_valid && d_iso && !ep_clr && !(ep_wr && reg_addr[4:2] == done_ep)
      |=> ($past(done_in) ? ep[dep_q][TX_TOG] : ep[dep_q][RX_TOG])
          != $past(d_tog)
          && ($past(done_in) ? ep[dep_q][5:4] : ep[dep_q][13:12])
          == $past(d_st);
  endproperty
  a_iso_tog: assert property (p_iso_tog) // RULE7
    else $error("toggle not flipped or state changed");

  property p_bus_reset;
    bus_reset |=> ep[0] == EP_RESET && ep[NUM_EP-1] == EP_RESET
      && addr_reg == 8'h00;
  endproperty
  a_bus_reset: assert property (p_bus_reset) // RULE12
    else $error("bus reset did not clear endpoints");

  property p_suspend;
    miss_hit && link == LINK_ACTIVE && !core_clr
      |=> link == LINK_SUSP && flags[FLG_SUSP] && suspended;
  endproperty
  a_suspend: assert property (p_suspend) // RULE14
    else $error("third missed frame did not suspend");

  property p_susp_reset;
    link == LINK_SUSP && bus_reset && !core_clr
      |=> link == LINK_ACTIVE && flags[FLG_RST];
  endproperty
  a_susp_reset: assert property (p_susp_reset) // RULE15
    else $error("bus reset missed while suspended");

  property p_resume_gate;
    ctrl_wr && !ctrl[CTRL_FSUSP] |=> !resume_drive;
  endproperty
  a_resume_gate: assert property (p_resume_gate) // RULE18
    else $error("resume request taken without force suspend");

  property p_irq_high;
    hp_any && ctrl[FLG_CTRS] |=> irq_high && irq_low;
  endproperty
  a_irq_high: assert property (p_irq_high) // RULE19
    else $error("high priority line not raised");

  property p_disabled;
    tok_valid && tok_st == ST_DIS |=> !ans_respond;
  endproperty
  a_disabled: assert property (p_disabled) // RULE23
    else $error("disabled endpoint answered");

  property p_pullup;
    whi && reg_addr == OFS_PULL |=> dp_pullup_en == $past(reg_wdata[25]);
  endproperty
  a_pullup: assert property (p_pullup) // RULE11
    else $error("pull-up bit not written");
endmodule

// ---- test/usbd_host_model.sv ----
// Host-side model: tokens, completions, frame markers and bus events
`timescale 1ns/100ps
module usbd_host_model (
  input wire logic mclk,
  output logic tok_valid,
  output logic [2:0] tok_ep,
  output logic tok_in,
  output logic done_valid,
  output logic [2:0] done_ep,
  output logic done_in,
  output logic done_crc_err,
  output logic done_overflow,
  output logic sof_seen,
  output logic [10:0] sof_frame,
  output logic bus_reset,
  output logic bus_activity,
  output logic dplus_level,
  output logic dminus_level
);
  logic sof_on = 1'b0;
  int cnt = 0;
  // Idle bus: no strobes, lines at idle J
  initial begin
    {tok_valid, tok_ep, tok_in, done_valid, done_ep, done_in} = '0;
    {done_crc_err, done_overflow, sof_seen, sof_frame, bus_reset} = '0;
    {bus_activity, dplus_level, dminus_level} = 3'b010;
  end
  // Frame marker every 15 cycles, faster than the tick so none is missed
  always @(posedge mclk) begin
    cnt <= (cnt == 14) ? 0 : cnt + 1;
    sof_seen <= sof_on && cnt == 0;
    sof_frame <= sof_frame + 11'h1;
  end
  task automatic token(input logic [2:0] ep, input logic in_dir);
    @(posedge mclk);
    tok_valid <= 1'b1;
    tok_ep <= ep;
    tok_in <= in_dir;
    @(posedge mclk);
    tok_valid <= 1'b0;
    tok_ep <= ~ep;
    @(negedge mclk);
  endtask
  task automatic done(input logic [2:0] ep, input logic in_dir,
                      input logic crc, input logic ovf);
    @(posedge mclk);
    done_valid <= 1'b1;
    done_ep <= ep;
    done_in <= in_dir;
    done_crc_err <= crc;
    done_overflow <= ovf;
    @(posedge mclk);
    done_valid <= 1'b0;
    done_ep <= ~ep;
  endtask
  task automatic bus_evt(input logic rst, input logic dp, input logic dm);
    @(posedge mclk);
    bus_reset <= rst;
    bus_activity <= ~rst;
    dplus_level <= dp;
    dminus_level <= dm;
    @(posedge mclk);
    bus_reset <= 1'b0;
    bus_activity <= 1'b0;
    dplus_level <= 1'b1;
    dminus_level <= 1'b0;
  endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the isochronous and bus event block
`timescale 1ns/100ps
module tb;
  import usbd_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [1:0] reg_lane = 2'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic ans_valid, ans_respond, ans_handshake, ans_stall, ans_nak;
  logic ans_data1, ans_buf_sel, irq_low, irq_high, irq_wakeup;
  logic dp_pullup_en, resume_drive, suspended, tok_valid, tok_in;
  logic [2:0] tok_ep, done_ep;
  logic done_valid, done_in, done_crc_err, done_overflow, sof_seen;
  logic [10:0] sof_frame;
  logic bus_reset, bus_activity, dplus_level, dminus_level;
  int errors = 0;
  int n_checks = 0;
  int seed = 21770;
  int cyc = 0;
  int tog = 0;
  int crc, m_ep1, n;
  usbd_iso_events #(.MS_CYCLES_P(20)) dut (.mclk, .rst_n, .reg_addr,
    .reg_wdata, .reg_lane, .reg_wr, .reg_rd, .reg_rdata, .tok_valid,
    .tok_ep, .tok_in, .ans_valid, .ans_respond, .ans_handshake, .ans_stall,
    .ans_nak, .ans_data1, .ans_buf_sel, .done_valid, .done_ep, .done_in,
    .done_crc_err, .done_overflow, .sof_seen, .sof_frame, .bus_reset,
    .bus_activity, .dplus_level, .dminus_level, .irq_low, .irq_high,
    .irq_wakeup, .dp_pullup_en, .resume_drive, .suspended);
  usbd_host_model host (.mclk, .tok_valid, .tok_ep, .tok_in, .done_valid,
    .done_ep, .done_in, .done_crc_err, .done_overflow, .sof_seen,
    .sof_frame, .bus_reset, .bus_activity, .dplus_level, .dminus_level);
  initial begin
    forever #50 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] l);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    reg_lane <= l;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_CTRL, d);
    chk(d, 32'h3);
    rd(8'hfc, d);
    chk(d, 32'h0);
    wr(OFS_CTRL, 32'h9000, 2'h1);
    host.sof_on = 1'b1;
    wr(OFS_PULL, 32'h0200_0000, 2'h2);
    chk(32'(dp_pullup_en), 32'h1);
    wr(OFS_ADDR, 32'h80, 2'h1);
    m_ep1 = 32'h3401;
    wr(8'h04, m_ep1, 2'h3);
    // Receive iso traffic with random errors; model tracks the toggle
    for (int i = 0; i < 6; i++) begin
      host.token(3'h1, 1'b0);
      chk(32'({ans_valid, ans_respond, ans_handshake, ans_data1, ans_buf_sel}),
          32'({4'b1100, tog[0]}));
      wr(OFS_STS, 32'h0, 2'h1);
      crc = $random(seed) & 1;
      host.done(3'h1, 1'b0, crc[0], i[1]);
      tog = tog ^ 1;
      m_ep1 = (m_ep1 & 32'h3fff) | 32'h8000 | (tog << 14);
      rd(8'h04, d);
      chk(d, m_ep1);
      rd(OFS_STS, d);
      chk(32'({d[15], d[13]}), 32'({1'b1, crc[0]}));
      chk(32'({irq_high, irq_low}), 32'h3);
      m_ep1 = m_ep1 & 32'h7fff;
      wr(8'h04, m_ep1, 2'h3);
    end
    wr(8'h08, 32'h0432, 2'h1);
    host.done(3'h2, 1'b1, 1'b0, 1'b0);
    rd(8'h08, d);
    chk(d, 32'h04f2);
    host.token(3'h2, 1'b1);
    chk(32'(ans_buf_sel), 32'h1);
    wr(8'h0c, 32'h3003, 2'h1);
    host.done(3'h3, 1'b0, 1'b0, 1'b0);
    rd(8'h0c, d);
    chk(d, 32'he003);
    host.token(3'h3, 1'b0);
    chk(32'({ans_respond, ans_handshake, ans_nak, ans_stall}),
        32'he);
    host.token(3'h4, 1'b0);
    chk(32'(ans_respond), 32'h0);
    // Frame markers stop: suspend after three missed ticks
    @(posedge sof_seen);
    host.sof_on = 1'b0;
    n = 0;
    while (suspended !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n >= 41 && n <= 62), 32'h1);
    rd(OFS_STS, d);
    chk(32'(d[11]), 32'h1);
    wr(OFS_CTRL, 32'h9010, 2'h1);
    chk(32'(resume_drive), 32'h0);
    host.bus_evt(1'b1, 1'b0, 1'b0);
    @(negedge mclk);
    chk(32'(suspended), 32'h0);
    rd(8'h04, d);
    chk(d, 32'h0);
    rd(OFS_STS, d);
    chk(32'(d[10]), 32'h1);
    rd(OFS_FN, d);
    chk(32'(d[15:14]), 32'h0);
    wr(OFS_CTRL, 32'h9008, 2'h1);
    wr(OFS_CTRL, 32'h9018, 2'h1);
    chk(32'({suspended, resume_drive}), 32'h3);
    wr(OFS_STS, 32'h0, 2'h1);
    host.bus_evt(1'b0, 1'b0, 1'b1);
    rd(OFS_FN, d);
    chk(32'(d[15:14]), 32'h1);
    chk(32'(irq_wakeup), 32'h1);
    end_sim();
  end
endmodule
